// >>> hw/byte_store.sv
// Small byte memory with one write port and a registered read port
`timescale 1ns/1ps
`include "loader_hist_defines.svh"

module byte_store #(
    parameter int DEPTH = 128,
    parameter int AW    = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [7:0]            q;
    } store_type;

    store_type s;
    store_type next_s;

    assign rdata = s.q;

    always_comb begin
        next_s = s;
        if (we && (int'(waddr) < DEPTH)) begin
            next_s.mem[waddr] = wdata;
        end
        // Out of range reads answer zero rather than wrapping
        if (int'(raddr) < DEPTH) begin
            next_s.q = s.mem[raddr];
        end else begin
            next_s.q = `ZERO_BYTE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule // byte_store

// >>> hw/loader_hist_defines.svh
// Offsets, codes and fixed values of the loader and histogram register pages
`ifndef LOADER_HIST_DEFINES_SVH
`define LOADER_HIST_DEFINES_SVH

// ****************************************************************
// Page selection
// ****************************************************************
`define APP_MAIN          8'h03
`define APP_LOADER        8'h80
`define CFG_HISTOGRAM     8'h81

// ****************************************************************
// Histogram page offsets and values
// ****************************************************************
`define HIST_INDEX_ADDR   8'h24
`define HIST_LENGTH_ADDR  8'h25
`define HIST_SLOT_ADDR    8'h26
`define HIST_FIRST_ADDR   8'h27
`define HIST_LAST_ADDR    8'hA6
`define HIST_CHUNK_LEN    8'h80
`define HIST_SLOT_BIT     0

// ****************************************************************
// Loader page offsets, status codes and checksum
// ****************************************************************
`define LDR_CMD_ADDR      8'h08
`define LDR_LEN_ADDR      8'h09
`define LDR_DATA_ADDR     8'h0A
`define LDR_LAST_ADDR     8'h8A
`define STAT_READY        8'h00
`define STAT_ERR_SIZE     8'h01
`define STAT_ERR_CSUM     8'h02
`define STAT_ERR_RANGE    8'h03
`define STAT_ERR_MORE     8'h04
`define LDR_CSUM_XOR      8'hFF
`define ZERO_BYTE         8'h00

`endif

// >>> hw/loader_hist_pages.sv
// Histogram readout page and loader mailbox page of the register map
//
// Behaviour
// - Histogram page only with app 0x03, config 0x81
// - Chunk length always reads 0x80
// - Timeslot bit: 0 first/none, 1 second
// - Chunk bytes at offsets 0x27 to 0xA6
// - Loader page only with app 0x80
// - Success leaves status 0x00
// - Size mismatch leaves status 0x01
// - Bad checksum or unknown command gives 0x02
// - Out of range access gives 0x03
// - Error with more detail gives 0x04
// - Host writes up to 128 payload bytes, count
// - Checksum is inverted 8-bit sum, device verifies
// - Checksum sits right after last payload byte
`timescale 1ns/1ps
`include "loader_hist_defines.svh"

module loader_hist_pages (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RSTN,
    // Page identifiers
    input  wire logic [7:0] APP_ID,
    input  wire logic [7:0] CONFIG_ID,
    // Register access
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic            REG_RVALID,
    // Histogram producer
    input  wire logic       HIST_WR,
    input  wire logic [6:0] HIST_BYTE,
    input  wire logic [7:0] HIST_DATA,
    input  wire logic       HIST_HDR_WR,
    input  wire logic [7:0] HIST_CHUNK,
    input  wire logic       HIST_SLOT,
    // Loader command executor
    output logic            LOADER_START,
    output logic      [7:0] LOADER_CMD,
    output logic      [7:0] LOADER_LEN,
    output logic            LOADER_BUSY,
    input  wire logic [7:0] EXEC_ADDR,
    output logic      [7:0] EXEC_DATA,
    input  wire logic       LOADER_DONE,
    input  wire logic [7:0] LOADER_RESULT
);

    loader_hist_pkg::pages_state_type s;
    loader_hist_pkg::pages_state_type next_s;

    logic       hist_page;
    logic       ldr_page;
    logic       hist_range;
    logic       ldr_range;
    logic [7:0] csum_addr;
    logic       hist_we;
    logic [6:0] hist_waddr;
    logic [7:0] hist_q;
    logic       ldr_we;
    logic [7:0] ldr_raddr;
    logic [7:0] ldr_q;

    // ****************************************************************
    // Page decode
    // ****************************************************************
    // histogram page select
    assign hist_page  = (APP_ID == `APP_MAIN) && (CONFIG_ID == `CFG_HISTOGRAM);
    assign ldr_page   = (APP_ID == `APP_LOADER);
    assign hist_range = (REG_ADDR >= `HIST_FIRST_ADDR) && (REG_ADDR <= `HIST_LAST_ADDR);
    assign ldr_range  = (REG_ADDR >= `LDR_DATA_ADDR) && (REG_ADDR <= `LDR_LAST_ADDR);
    // checksum follows the last payload byte
    assign csum_addr  = 8'(`LDR_DATA_ADDR + s.len);

    // ****************************************************************
    // Byte stores
    // ****************************************************************
    // Producer wins over a host write in the same cycle
    assign hist_we    = HIST_WR || (REG_WR && hist_page && hist_range);
    assign hist_waddr = HIST_WR ? HIST_BYTE : 7'(REG_ADDR - `HIST_FIRST_ADDR);
    // Payload is frozen while a command is checked or run
    assign ldr_we     = REG_WR && ldr_page && ldr_range && !s.busy;
    always_comb begin
        unique case (s.st)
            loader_hist_pkg::LDR_SCAN: ldr_raddr = s.cnt;
            loader_hist_pkg::LDR_EXEC: ldr_raddr = EXEC_ADDR;
            loader_hist_pkg::LDR_IDLE,
            loader_hist_pkg::LDR_CHECK: ldr_raddr = 8'(REG_ADDR - `LDR_DATA_ADDR);
        endcase
    end

    byte_store #(
        .DEPTH (128),
        .AW    (7)
    ) hist_store (
        .clk   (CLK),
        .rstn  (RSTN),
        .we    (hist_we),
        .waddr (hist_waddr),
        .wdata (HIST_WR ? HIST_DATA : REG_WDATA),
        .raddr (7'(REG_ADDR - `HIST_FIRST_ADDR)),
        .rdata (hist_q)
    );

    // One extra entry holds the checksum of a full 128 byte payload
    byte_store #(
        .DEPTH (129),
        .AW    (8)
    ) ldr_store (
        .clk   (CLK),
        .rstn  (RSTN),
        .we    (ldr_we),
        .waddr (8'(REG_ADDR - `LDR_DATA_ADDR)),
        .wdata (REG_WDATA),
        .raddr (ldr_raddr),
        .rdata (ldr_q)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s       = s;
        next_s.start = 1'b0;
        next_s.rd1   = REG_RD;
        next_s.rvalid = s.rd1;
        if (REG_RD) begin
            next_s.rd_addr = REG_ADDR;
        end
        if (REG_WR && hist_page && (REG_ADDR == `HIST_INDEX_ADDR)) begin
            next_s.chunk = REG_WDATA;
        end
        // only bit 0 of the slot register is stored
        if (REG_WR && hist_page && (REG_ADDR == `HIST_SLOT_ADDR)) begin
            next_s.slot = REG_WDATA[`HIST_SLOT_BIT];
        end
        // Producer header update wins over a host write
        if (HIST_HDR_WR) begin
            next_s.chunk = HIST_CHUNK;
            next_s.slot  = HIST_SLOT;
        end
        unique case (s.st)
            loader_hist_pkg::LDR_IDLE: begin
                if (REG_WR && ldr_page && (REG_ADDR == `LDR_CMD_ADDR)) begin
                    next_s.cmd = REG_WDATA;
                end
                if (REG_WR && ldr_page && (REG_ADDR == `LDR_LEN_ADDR)) begin
                    next_s.len = REG_WDATA;
                end
                if (REG_WR && ldr_page && (REG_ADDR == csum_addr)) begin
                    next_s.csum = REG_WDATA;
                    next_s.sum  = 8'(s.cmd + s.len);
                    next_s.cnt  = `ZERO_BYTE;
                    next_s.pend = 1'b0;
                    next_s.busy = 1'b1;
                    next_s.st   = loader_hist_pkg::LDR_SCAN;
                end
            end
            loader_hist_pkg::LDR_SCAN: begin
                // sum payload bytes, one read per cycle
                next_s.pend = (s.cnt < s.len);
                if (s.cnt < s.len) begin
                    next_s.cnt = 8'(s.cnt + 8'h01);
                end
                if (s.pend) begin
                    next_s.sum = 8'(s.sum + ldr_q);
                end
                if (!(s.cnt < s.len) && !s.pend) begin
                    next_s.st = loader_hist_pkg::LDR_CHECK;
                end
            end
            loader_hist_pkg::LDR_CHECK: begin
                // faulty checksum never reaches the executor
                if ((s.sum ^ `LDR_CSUM_XOR) != s.csum) begin
                    next_s.cmd  = `STAT_ERR_CSUM;
                    next_s.busy = 1'b0;
                    next_s.st   = loader_hist_pkg::LDR_IDLE;
                end else begin
                    next_s.start = 1'b1;
                    next_s.st    = loader_hist_pkg::LDR_EXEC;
                end
            end
            loader_hist_pkg::LDR_EXEC: begin
                if (LOADER_DONE) begin
                    next_s.cmd  = LOADER_RESULT;
                    next_s.busy = 1'b0;
                    next_s.st   = loader_hist_pkg::LDR_IDLE;
                end
            end
        endcase

        // ************************************************************
        // Read answer, two cycles after the request
        // ************************************************************
        if (s.rd1) begin
            next_s.rdata = `ZERO_BYTE;
            if (hist_page) begin
                if (s.rd_addr == `HIST_INDEX_ADDR) begin
                    next_s.rdata = s.chunk;
                end else if (s.rd_addr == `HIST_LENGTH_ADDR) begin
                    next_s.rdata = `HIST_CHUNK_LEN;
                end else if (s.rd_addr == `HIST_SLOT_ADDR) begin
                    next_s.rdata = {7'h00, s.slot};
                end else if ((s.rd_addr >= `HIST_FIRST_ADDR)
                             && (s.rd_addr <= `HIST_LAST_ADDR)) begin
                    next_s.rdata = hist_q;
                end
            end else if (ldr_page) begin
                if (s.rd_addr == `LDR_CMD_ADDR) begin
                    next_s.rdata = s.cmd;
                end else if (s.rd_addr == `LDR_LEN_ADDR) begin
                    next_s.rdata = s.len;
                end else if ((s.rd_addr >= `LDR_DATA_ADDR) && (s.rd_addr <= `LDR_LAST_ADDR)
                             && (s.st == loader_hist_pkg::LDR_IDLE) && !s.busy) begin
                    next_s.rdata = ldr_q;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            // Idle state and ready status both encode as zero
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign REG_RDATA    = s.rdata;
    assign REG_RVALID   = s.rvalid;
    assign LOADER_START = s.start;
    assign LOADER_CMD   = s.cmd;
    assign LOADER_LEN   = s.len;
    assign LOADER_BUSY  = s.busy;
    assign EXEC_DATA    = ldr_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    chk_page_hidden: assert property (
        (REG_RD ##1 (!hist_page && !ldr_page)) |=> (REG_RDATA == `ZERO_BYTE))
        else $error("unselected page did not read zero");
    chk_length_fixed: assert property (
        (REG_RD && (REG_ADDR == `HIST_LENGTH_ADDR) ##1 hist_page)
        |=> (REG_RDATA == `HIST_CHUNK_LEN) && REG_RVALID)
        else $error("chunk length not 0x80");
    chk_slot_read: assert property (
        (REG_RD && (REG_ADDR == `HIST_SLOT_ADDR) ##1 hist_page)
        |=> (REG_RDATA == {7'h00, $past(s.slot)}))
        else $error("timeslot readback wrong");
    chk_chunk_first: assert property (
        (HIST_WR && (HIST_BYTE == 7'h00) && !HIST_HDR_WR)
        ##1 (REG_RD && (REG_ADDR == `HIST_FIRST_ADDR) && !HIST_WR && hist_page)
        ##1 hist_page |=> (REG_RDATA == $past(HIST_DATA, 3)))
        else $error("first chunk byte not at its offset");
    chk_csum_start: assert property (
        (REG_WR && ldr_page && !s.busy && (REG_ADDR == csum_addr))
        |=> (s.st == loader_hist_pkg::LDR_SCAN) && LOADER_BUSY)
        else $error("checksum write did not start validation");
    chk_csum_reject: assert property (
        ((s.st == loader_hist_pkg::LDR_CHECK) && ((s.sum ^ `LDR_CSUM_XOR) != s.csum))
        |=> (LOADER_CMD == `STAT_ERR_CSUM) && !LOADER_START && !LOADER_BUSY)
        else $error("bad checksum not reported");
    chk_exec_pulse: assert property (
        ((s.st == loader_hist_pkg::LDR_CHECK) && ((s.sum ^ `LDR_CSUM_XOR) == s.csum))
        |=> LOADER_START ##1 !LOADER_START)
        else $error("good frame not handed to executor once");
    chk_status_result: assert property (
        ((s.st == loader_hist_pkg::LDR_EXEC) && LOADER_DONE)
        |=> (LOADER_CMD == $past(LOADER_RESULT)) && !LOADER_BUSY)
        else $error("status not replaced by result");
    chk_scan_bound: assert property (
        $rose(LOADER_BUSY) |-> ##[1:300] (s.st != loader_hist_pkg::LDR_SCAN))
        else $error("payload scan did not finish");
    chk_busy_freeze: assert property (
        (LOADER_BUSY && !LOADER_DONE) |=> $stable(LOADER_LEN))
        else $error("length changed while busy");

    cov_csum_bad: cover property (
        (s.st == loader_hist_pkg::LDR_CHECK) && ((s.sum ^ `LDR_CSUM_XOR) != s.csum));
    cov_exec_done: cover property (LOADER_START ##[1:50] LOADER_DONE);
    cov_hist_read: cover property (REG_RD && hist_page && hist_range);
    cov_full_frame: cover property (LOADER_START && (LOADER_LEN == `HIST_CHUNK_LEN));

endmodule // loader_hist_pages

// >>> hw/loader_hist_pkg.sv
// Types shared by the loader and histogram register pages
package loader_hist_pkg;

    typedef enum logic [1:0] {
        LDR_IDLE,
        LDR_SCAN,
        LDR_CHECK,
        LDR_EXEC
    } loader_state_type;

    typedef struct packed {
        loader_state_type st;
        logic [7:0]       cmd;
        logic [7:0]       len;
        logic [7:0]       csum;
        logic [7:0]       sum;
        logic [7:0]       cnt;
        logic             pend;
        logic             start;
        logic             busy;
        logic [7:0]       chunk;
        logic             slot;
        logic             rd1;
        logic [7:0]       rd_addr;
        logic [7:0]       rdata;
        logic             rvalid;
    } pages_state_type;

endpackage

// >>> test/loader_executor_model.sv
// Behavioural loader command executor that answers the mailbox page
`timescale 1ns/1ps

module loader_executor_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Command from the mailbox
    input  wire logic       start,
    input  wire logic [7:0] len,
    input  wire logic [7:0] exec_data,
    output logic      [7:0] exec_addr,
    // Answer chosen by the bench
    input  wire logic [7:0] answer,
    input  wire logic [7:0] delay,
    output logic            done,
    output logic      [7:0] result,
    output logic      [7:0] data_sum
);
    logic       running;
    logic [8:0] cnt;

    // ****************************************
    // Payload scan and result
    // ****************************************
    // one status code per command
    always @(posedge clk) begin
        done <= 1'b0;
        // Result outside the done pulse carries no stale copy
        result <= ~answer;
        if (!rstn) begin
            running <= 1'b0;
            cnt <= 9'h000;
            exec_addr <= 8'h00;
        end else if (start) begin
            running <= 1'b1;
            cnt <= 9'h001;
            exec_addr <= 8'h00;
            data_sum <= 8'h00;
        end else if (running) begin
            cnt <= cnt + 9'h001;
            exec_addr <= cnt[7:0];
            // Store answers one cycle late, so data lags the index by two edges
            if (cnt >= 9'h002 && cnt <= {1'b0, len} + 9'h001) begin
                data_sum <= data_sum + exec_data;
            end
            if (cnt == {1'b0, len} + 9'h002 + {1'b0, delay}) begin
                done <= 1'b1;
                result <= answer;
                running <= 1'b0;
            end
        end
    end

endmodule // loader_executor_model

// >>> test/test_loader_hist_pages.sv
// Self-checking bench for the histogram and loader register pages
`timescale 1ns/1ps

module test_loader_hist_pages;
    logic       clk, rstn, reg_wr, reg_rd, rvalid, hist_wr, hist_hdr_wr, hist_slot;
    logic       start, busy, done;
    logic [7:0] app_id, config_id, reg_addr, reg_wdata, rdata, hist_data, hist_chunk;
    logic [7:0] cmd_out, len_out, exec_addr, exec_data, result, answer, delay, data_sum;
    logic [6:0] hist_byte;
    int         n_fail = 0;
    int         cmp_count = 0;
    int         n_start = 0;

    always #10 clk = ~clk;
    always @(posedge clk) if (rstn && start === 1'b1) n_start <= n_start + 1;

    loader_hist_pages loader_hist_pages_inst (
        .CLK(clk), .RSTN(rstn), .APP_ID(app_id), .CONFIG_ID(config_id),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .HIST_WR(hist_wr), .HIST_BYTE(hist_byte),
        .HIST_DATA(hist_data), .HIST_HDR_WR(hist_hdr_wr), .HIST_CHUNK(hist_chunk),
        .HIST_SLOT(hist_slot), .LOADER_START(start), .LOADER_CMD(cmd_out),
        .LOADER_LEN(len_out), .LOADER_BUSY(busy), .EXEC_ADDR(exec_addr),
        .EXEC_DATA(exec_data), .LOADER_DONE(done), .LOADER_RESULT(result));

    loader_executor_model loader_executor_model_inst (
        .clk(clk), .rstn(rstn), .start(start), .len(len_out), .exec_data(exec_data),
        .exec_addr(exec_addr), .answer(answer), .delay(delay), .done(done),
        .result(result), .data_sum(data_sum));

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        int k;
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        for (k = 0; k < 4 && rvalid !== 1'b1; k++) @(negedge clk);
        check("read answer", 8'h01, {7'h00, rvalid});
        check(what, exp, rdata);
        @(negedge clk);
    endtask

    task automatic put_byte(input logic [6:0] idx, input logic [7:0] d);
        hist_wr = 1'b1;
        hist_byte = idx;
        hist_data = d;
        @(negedge clk);
        // Returns at once so a read can follow the byte in the next cycle
        hist_wr = 1'b0;
    endtask

    task automatic put_header(input logic [7:0] chunk, input logic slot);
        hist_hdr_wr = 1'b1;
        hist_chunk = chunk;
        hist_slot = slot;
        @(negedge clk);
        hist_hdr_wr = 1'b0;
        @(negedge clk);
    endtask

    function automatic logic [7:0] pay(input int i);
        return 8'(i * 7 + 3);
    endfunction

    // frame written by the host, checksum last
    task automatic send(input logic [7:0] cmd, input logic [7:0] len, input logic [7:0] ans,
                        input logic [7:0] dly, input logic good);
        logic [7:0] sum;
        logic [7:0] psum;
        int         i;
        int         s0;
        s0 = n_start;
        answer = ans;
        delay = dly;
        psum = 8'h00;
        wr(8'h08, cmd);
        wr(8'h09, len);
        for (i = 0; i < len; i++) begin
            wr(8'h0A + i[7:0], pay(i));
            psum = psum + pay(i);
        end
        sum = cmd + len + psum;
        wr(8'h0A + len, good ? sum ^ 8'hFF : sum);
        for (i = 0; i < 8 && busy !== 1'b1; i++) @(negedge clk);
        check("busy after checksum", 8'h01, {7'h00, busy});
        wr(8'h09, ~len);
        for (i = 0; i < 800 && busy !== 1'b0; i++) @(negedge clk);
        check("idle after command", 8'h00, {7'h00, busy});
        check("start count", good ? 8'h01 : 8'h00, 8'(n_start - s0));
        if (good) check("payload at executor", psum, data_sum);
        rd(8'h08, good ? ans : 8'h02, "command status");
        rd(8'h09, len, "length held while busy");
        if (len != 8'h00) rd(8'h09 + len, pay(len - 1), "last payload byte");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {clk, rstn, reg_wr, reg_rd, hist_wr, hist_hdr_wr, hist_slot} = 7'h00;
        {reg_addr, reg_wdata, hist_data, hist_chunk, answer, delay} = 48'h0000_0000_0000;
        hist_byte = 7'h00;
        app_id = 8'h03;
        config_id = 8'h81;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        rd(8'h24, 8'h00, "chunk index reset");
        rd(8'h25, 8'h80, "chunk length reset");
        rd(8'h26, 8'h00, "slot reset");
        wr(8'h25, 8'h12);
        rd(8'h25, 8'h80, "chunk length after write");
        wr(8'h26, 8'hFF);
        rd(8'h26, 8'h01, "slot bit only");
        wr(8'h24, 8'h33);
        rd(8'h24, 8'h33, "chunk index write");
        put_header(8'h5A, 1'b1);
        rd(8'h24, 8'h5A, "producer chunk index");
        rd(8'h26, 8'h01, "second timeslot");
        put_header(8'h5B, 1'b0);
        rd(8'h26, 8'h00, "first timeslot");
        for (int i = 0; i < 7; i++) begin
            put_byte(7'h7F >> i, 8'hC0 + 8'(i));
            rd(8'h27 + 8'(7'h7F >> i), 8'hC0 + 8'(i), "chunk byte");
        end
        put_byte(7'h00, 8'h5E);
        rd(8'h27, 8'h5E, "first chunk byte");
        rd(8'hA7, 8'h00, "past last chunk byte");
        $display("test histogram page done");
        config_id = 8'h80;
        rd(8'h25, 8'h00, "length with other config");
        app_id = 8'h80;
        config_id = 8'h81;
        rd(8'hA6, 8'h00, "chunk byte on loader app");
        app_id = 8'h03;
        wr(8'h08, 8'h41);
        rd(8'h08, 8'h00, "status hidden on main app");
        app_id = 8'h80;
        rd(8'h08, 8'h00, "status write from main app");
        $display("test page selection done");
        send(8'h41, 8'd3, 8'h00, 8'd0, 1'b1);
        send(8'h43, 8'd2, 8'h01, 8'd5, 1'b1);
        send(8'h2A, 8'd0, 8'h02, 8'd0, 1'b1);
        send(8'h41, 8'd128, 8'h03, 8'd20, 1'b1);
        send(8'h14, 8'd1, 8'h04, 8'd2, 1'b1);
        send(8'h41, 8'd2, 8'h00, 8'd0, 1'b0);
        $display("test loader commands done");
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        rd(8'h08, 8'h00, "status after reset");
        rd(8'h09, 8'h00, "length after reset");
        $display("test second reset done");
        final_report();
    end

    initial begin
        #400_000;
        n_fail++;
        final_report();
    end

endmodule // test_loader_hist_pages
